// >>> password_gated_monitor_flag_regs.sv
// Register bank: live monitor-3 warnings, password entry, page select, page-one latched flags
`timescale 1ns/1ps
// How it works
// - Live bit7 follows monitor-3 above-high result
// - Live bit6 follows monitor-3 below-low result
// - Reserved lower block always reads zero
// - Password entry writable by all, reads zero
// - Password entry resets to all ones
// - Two four-byte passwords, two levels
// - Lower level gets user plus lower rights
// - Upper level includes all lower level rights
// - Reference passwords come from upper-level storage
// - Page select: reset zero, any level
// - Page one bytes need lower level
// - Latched copy of third alarm group
// - Latched alarm supply-low not set at power-on
// - Latched bits sticky; lower-level write clears
// - Latched copy of monitor-3 alarms
// - Latched copy of first alarm group
// - Latched copy of bias-maximum flag bit3
// - Latched copy of third warning group
// - Latched warning supply-low not set at power-on
// - Supply-low set below trip, clears on a good measurement
// - Latched copy of monitor-3 warnings
module password_gated_monitor_flag_regs
    import pgm_regs_pkg::*;
#(
    parameter int NV_BYTES = NV_DEPTH
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    input  wire reg_req_t     req,
    input  wire live_flags_t  live,
    input  wire mon_meas_t    third_monitor_input,
    input  wire supply_meas_t supply,
    input  wire logic [31:0]  lower_ref_pass,
    input  wire logic [31:0]  upper_ref_pass,
    output logic [7:0]        reg_rdata,
    output logic              reg_rd_valid,
    output logic [7:0]        page_select,
    output logic [7:0]        monitor3_warning_live,
    output logic              supply_low_flag,
    output logic              lower_access_level,
    output logic              upper_access_level
);

    localparam int NV_AW = 7;

    // Byte index is seven bits wide; the depth must equal the documented page-one byte window
    if (NV_BYTES != int'(NV_LAST) - int'(NV_FIRST) + 1) begin : g_bad_nv_bytes
        $error("NV_BYTES must match the page-one byte window");
    end

    state_t     s_r;
    state_t     s_nxt;
    logic [7:0] nv_mem [NV_BYTES];

    logic             on_page1;
    logic             in_nv;
    logic             nv_wr;
    logic [NV_AW-1:0] nv_idx;
    logic             lat_wr_ok;
    latched_t         lat_set;
    latched_t         lat_clr;

    // Decode shared by the state update and the byte store
    always_comb begin
        on_page1  = (s_r.page == PAGE_LATCHED);
        in_nv     = on_page1 && (req.addr >= NV_FIRST) && (req.addr <= NV_LAST);
        nv_idx    = NV_AW'(req.addr - NV_FIRST);
        nv_wr     = req.wr && in_nv && s_r.lvl1;
        lat_wr_ok = req.wr && on_page1 && s_r.lvl1;
    end

    // Events that set the latched copies; supply-low is held off until armed
    always_comb begin
        lat_set.a3 = live.latched_alarm_group3 & MASK_GROUP3;
        lat_set.a3[SUPPLY_LO_BIT] = live.latched_alarm_group3[SUPPLY_LO_BIT] & s_r.armed;
        lat_set.a2 = live.latched_alarm_group2 & MASK_A2;
        lat_set.a1 = live.latched_alarm_group1 & MASK_A1;
        lat_set.a0 = live.alarm0 & MASK_A0;
        lat_set.w3 = live.latched_warning_group3 & MASK_GROUP3;
        lat_set.w3[SUPPLY_LO_BIT] = s_r.supply_low & s_r.armed;
        lat_set.w2 = s_r.third_monitor_input_warn & MASK_W2;
    end

    // Any write to a latched register by a privileged host clears it whole
    always_comb begin
        lat_clr.a3 = {8{lat_wr_ok && req.addr == LAT_A3_ADDR}};
        lat_clr.a2 = {8{lat_wr_ok && req.addr == LAT_A2_ADDR}};
        lat_clr.a1 = {8{lat_wr_ok && req.addr == LAT_A1_ADDR}};
        lat_clr.a0 = {8{lat_wr_ok && req.addr == LAT_A0_ADDR}};
        lat_clr.w3 = {8{lat_wr_ok && req.addr == LAT_W3_ADDR}};
        lat_clr.w2 = {8{lat_wr_ok && req.addr == LAT_W2_ADDR}};
    end

    always_comb begin
        s_nxt          = s_r;
        s_nxt.rd_valid = 1'b0;

        // Live monitor-3 warnings only move when a conversion completes
        if (third_monitor_input.done) begin
            s_nxt.third_monitor_input_warn[THIRD_INPUT_HIGH_FLAG_BIT] = third_monitor_input.above_high;
            s_nxt.third_monitor_input_warn[THIRD_INPUT_LOW_FLAG_BIT] = third_monitor_input.below_low;
        end

        // Trip point dominates; a good measurement is the only release
        if (supply.below_trip) begin
            s_nxt.supply_low = 1'b1;
        end else if (supply.done && supply.above_low) begin
            s_nxt.supply_low = 1'b0;
        end
        if (!s_r.supply_low) begin
            s_nxt.armed = 1'b1;
        end

        // Most significant byte sits at the lowest address
        if (req.wr) begin
            case (req.addr)
                PASS_FIRST: begin
                    s_nxt.entry[31:24] = req.wdata;
                end
                PASS_FIRST + 8'h01: begin
                    s_nxt.entry[23:16] = req.wdata;
                end
                PASS_FIRST + 8'h02: begin
                    s_nxt.entry[15:8] = req.wdata;
                end
                PASS_LAST: begin
                    s_nxt.entry[7:0] = req.wdata;
                end
                PAGE_SEL_ADDR: begin
                    s_nxt.page = req.wdata;
                end
                default: begin
                end
            endcase
        end

        // Grants track the registered entry, so they settle one cycle after a write
        s_nxt.lvl2 = (s_r.entry == upper_ref_pass);
        s_nxt.lvl1 = s_nxt.lvl2 || (s_r.entry == lower_ref_pass);

        // Set wins over a clear in the same cycle
        s_nxt.lat = (s_r.lat & ~lat_clr) | lat_set;

        if (req.rd) begin
            s_nxt.rd_valid = 1'b1;
            s_nxt.rdata    = READ_ZERO;
            if (req.addr == THIRD_MONITOR_INPUT_WARN_ADDR) begin
                s_nxt.rdata = s_r.third_monitor_input_warn;
            end else if (req.addr == PAGE_SEL_ADDR) begin
                s_nxt.rdata = s_r.page;
            end else if (in_nv) begin
                s_nxt.rdata = s_r.lvl1 ? nv_mem[nv_idx] : READ_ZERO;
            end else if (on_page1) begin
                case (req.addr)
                    LAT_A3_ADDR: begin
                        s_nxt.rdata = s_r.lat.a3;
                    end
                    LAT_A2_ADDR: begin
                        s_nxt.rdata = s_r.lat.a2;
                    end
                    LAT_A1_ADDR: begin
                        s_nxt.rdata = s_r.lat.a1;
                    end
                    LAT_A0_ADDR: begin
                        s_nxt.rdata = s_r.lat.a0;
                    end
                    LAT_W3_ADDR: begin
                        s_nxt.rdata = s_r.lat.w3;
                    end
                    LAT_W2_ADDR: begin
                        s_nxt.rdata = s_r.lat.w2;
                    end
                    default: begin
                        s_nxt.rdata = READ_ZERO;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r            <= '0;
            s_r.third_monitor_input_warn  <= THIRD_MONITOR_INPUT_WARN_RST;
            s_r.entry      <= PASS_RST;
            s_r.page       <= PAGE_RST;
            s_r.lat        <= {6{LATCH_RST}};
            s_r.supply_low <= 1'b1;
            s_r.rdata      <= READ_ZERO;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    // Nonvolatile contents keep no reset; power loss is modelled outside
    always_ff @(posedge ref_clk) begin
        if (clk_en && nv_wr) begin
            nv_mem[nv_idx] <= req.wdata;
        end
    end

    assign reg_rdata             = s_r.rdata;
    assign reg_rd_valid          = s_r.rd_valid;
    assign page_select           = s_r.page;
    assign monitor3_warning_live = s_r.third_monitor_input_warn;
    assign supply_low_flag       = s_r.supply_low;
    assign lower_access_level    = s_r.lvl1;
    assign upper_access_level    = s_r.lvl2;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_read_at(logic [7:0] a);
        clk_en && req.rd && req.addr == a;
    endsequence

    sequence s_zero_answer;
        ##1 reg_rd_valid && reg_rdata == READ_ZERO;
    endsequence

    sequence s_entry_written;
        clk_en && req.wr && req.addr >= PASS_FIRST && req.addr <= PASS_LAST;
    endsequence

    a_third_monitor_input_high_flag: assert property (
        clk_en && third_monitor_input.done |=> monitor3_warning_live[THIRD_INPUT_HIGH_FLAG_BIT] == $past(third_monitor_input.above_high))
        else $error("monitor-3 high warning does not follow measurement");

    a_third_monitor_input_low_flag: assert property (
        clk_en && third_monitor_input.done |=> monitor3_warning_live[THIRD_INPUT_LOW_FLAG_BIT] == $past(third_monitor_input.below_low))
        else $error("monitor-3 low warning does not follow measurement");

    a_third_monitor_input_flag_hold: assert property (
        clk_en && !third_monitor_input.done |=> $stable(monitor3_warning_live))
        else $error("live monitor-3 warnings moved without a measurement");

    a_rsvd_reads_zero: assert property (
        clk_en && req.rd && req.addr >= RSVD_LO_FIRST && req.addr <= RSVD_LO_LAST
        |-> s_zero_answer)
        else $error("reserved lower location read non-zero");

    a_pass_reads_zero: assert property (
        clk_en && req.rd && req.addr >= PASS_FIRST && req.addr <= PASS_LAST
        |-> s_zero_answer)
        else $error("password entry read returned data");

    a_pass_msb_first: assert property (
        clk_en && req.wr && req.addr == PASS_FIRST
        |=> s_r.entry[31:24] == $past(req.wdata) && s_r.entry[23:0] == $past(s_r.entry[23:0]))
        else $error("password high byte not stored at lowest address");

    a_grant_follows: assert property (
        s_entry_written ##1 clk_en
        |=> lower_access_level == ($past(s_r.entry) == $past(lower_ref_pass)
                                   || $past(s_r.entry) == $past(upper_ref_pass)))
        else $error("lower level grant does not match entry");

    a_upper_implies_lower: assert property (
        upper_access_level |-> lower_access_level)
        else $error("upper level granted without lower level");

    a_upper_grant: assert property (
        clk_en |=> upper_access_level == ($past(s_r.entry) == $past(upper_ref_pass)))
        else $error("upper level grant does not match entry");

    a_page_write: assert property (
        clk_en && req.wr && req.addr == PAGE_SEL_ADDR |=> page_select == $past(req.wdata))
        else $error("page select write not taken");

    a_page_read: assert property (
        s_read_at(PAGE_SEL_ADDR) |=> reg_rd_valid && reg_rdata == $past(page_select))
        else $error("page select read wrong");

    a_nv_locked: assert property (
        clk_en && req.rd && in_nv && !lower_access_level |-> s_zero_answer)
        else $error("page-one byte readable without lower level");

    a_latch_sets: assert property (
        clk_en && live.latched_alarm_group1[7] |=> s_r.lat.a1[7])
        else $error("latched copy missed a live flag");

    a_latch_sticky: assert property (
        clk_en && s_r.lat.w2[THIRD_INPUT_HIGH_FLAG_BIT] && !(lat_wr_ok && req.addr == LAT_W2_ADDR)
        |=> s_r.lat.w2[THIRD_INPUT_HIGH_FLAG_BIT])
        else $error("latched warning dropped without a clear");

    a_latch_clears: assert property (
        clk_en && lat_wr_ok && req.addr == LAT_A2_ADDR && live.latched_alarm_group2 == 8'h00
        |=> s_r.lat.a2 == 8'h00)
        else $error("privileged write did not clear latched alarm");

    a_no_poweron_vlo: assert property (
        !s_r.armed |-> !s_r.lat.a3[SUPPLY_LO_BIT] && !s_r.lat.w3[SUPPLY_LO_BIT])
        else $error("latched supply-low set before arming");

    a_supply_release: assert property (
        clk_en && !supply.below_trip && supply.done && supply.above_low
        |=> !supply_low_flag ##1 (s_r.armed || !$past(clk_en)))
        else $error("supply-low did not clear on good measurement");

    a_reserved_mask: assert property (
        (s_r.lat.a0 & ~MASK_A0) == 8'h00 && (s_r.lat.a1 & ~MASK_A1) == 8'h00)
        else $error("undefined latched alarm bits set");

    a_pass_second_byte: assert property (
        clk_en && req.wr && req.addr == PASS_FIRST + 8'h01
        |=> s_r.entry[23:16] == $past(req.wdata))
        else $error("password second byte not stored");

    a_pass_third_byte: assert property (
        clk_en && req.wr && req.addr == PASS_FIRST + 8'h02
        |=> s_r.entry[15:8] == $past(req.wdata))
        else $error("password third byte not stored");

    a_pass_last_byte: assert property (
        clk_en && req.wr && req.addr == PASS_LAST
        |=> s_r.entry[7:0] == $past(req.wdata))
        else $error("password low byte not stored at highest address");

    a_lower_grant: assert property (
        clk_en
        |=> lower_access_level == ($past(s_r.entry) == $past(lower_ref_pass)
                                   || $past(s_r.entry) == $past(upper_ref_pass)))
        else $error("lower level grant does not track entry");

    a_latch_exact: assert property (
        clk_en && !lat_wr_ok
        |=> s_r.lat == $past(s_r.lat | lat_set))
        else $error("latched copies changed without a privileged write");

    a_set_beats_clear: assert property (
        clk_en
        |=> (s_r.lat & $past(lat_set)) == $past(lat_set))
        else $error("live flag lost against a clear");

    a_clear_needs_level: assert property (
        clk_en && req.wr && req.addr == LAT_A3_ADDR && !lower_access_level
        |=> s_r.lat.a3 == $past(s_r.lat.a3 | lat_set.a3))
        else $error("latched alarm cleared without lower level");

    a_monitor3_warning_live_copy: assert property (
        clk_en && monitor3_warning_live[THIRD_INPUT_HIGH_FLAG_BIT]
        |=> s_r.lat.w2[THIRD_INPUT_HIGH_FLAG_BIT])
        else $error("latched monitor-3 warning missed the live flag");

    a_bias_max_copy: assert property (
        clk_en && (live.alarm0 & MASK_A0) != 8'h00
        |=> (s_r.lat.a0 & MASK_A0) == MASK_A0)
        else $error("latched bias-maximum flag missed");

    a_trip_sets_flag: assert property (
        clk_en && supply.below_trip
        |=> supply_low_flag)
        else $error("supply-low not set below trip point");

    a_page_gate: assert property (
        clk_en && req.rd && req.addr >= NV_FIRST && page_select != PAGE_LATCHED
        |-> s_zero_answer)
        else $error("upper address off page one read non-zero");

    a_armed_warn_latch: assert property (
        clk_en && s_r.armed && s_r.supply_low
        |=> s_r.lat.w3[SUPPLY_LO_BIT])
        else $error("armed supply-low warning not latched");

    a_armed_alarm_latch: assert property (
        clk_en && s_r.armed && live.latched_alarm_group3[SUPPLY_LO_BIT]
        |=> s_r.lat.a3[SUPPLY_LO_BIT])
        else $error("armed supply-low alarm not latched");

endmodule // password_gated_monitor_flag_regs

// >>> pgm_regs_pkg.sv
// Shared address map, field layout, reset values and carrier types for the flag register bank
package pgm_regs_pkg;

    // Lower memory
    localparam logic [7:0]  THIRD_MONITOR_INPUT_WARN_ADDR  = 8'h75;
    localparam logic [7:0]  RSVD_LO_FIRST   = 8'h76;
    localparam logic [7:0]  RSVD_LO_LAST    = 8'h7a;
    localparam logic [7:0]  PASS_FIRST      = 8'h7b;
    localparam logic [7:0]  PASS_LAST       = 8'h7e;
    localparam logic [7:0]  PAGE_SEL_ADDR   = 8'h7f;

    // Upper memory, page one
    localparam logic [7:0]  PAGE_LATCHED    = 8'h01;
    localparam logic [7:0]  NV_FIRST        = 8'h80;
    localparam logic [7:0]  NV_LAST         = 8'hf7;
    localparam logic [7:0]  LAT_A3_ADDR     = 8'hf8;
    localparam logic [7:0]  LAT_A2_ADDR     = 8'hf9;
    localparam logic [7:0]  LAT_A1_ADDR     = 8'hfa;
    localparam logic [7:0]  LAT_A0_ADDR     = 8'hfb;
    localparam logic [7:0]  LAT_W3_ADDR     = 8'hfc;
    localparam logic [7:0]  LAT_W2_ADDR     = 8'hfd;
    localparam int          NV_DEPTH        = 120;

    // Reset values
    localparam logic [7:0]  THIRD_MONITOR_INPUT_WARN_RST   = 8'h10;
    localparam logic [31:0] PASS_RST        = 32'hffffffff;
    localparam logic [7:0]  PAGE_RST        = 8'h00;
    localparam logic [7:0]  LATCH_RST       = 8'h00;
    localparam logic [7:0]  READ_ZERO       = 8'h00;

    // Field positions and defined-bit masks
    localparam int          THIRD_INPUT_HIGH_FLAG_BIT     = 7;
    localparam int          THIRD_INPUT_LOW_FLAG_BIT     = 6;
    localparam int          SUPPLY_LO_BIT   = 4;
    localparam logic [7:0]  MASK_GROUP3     = 8'hff;
    localparam logic [7:0]  MASK_A2         = 8'hc0;
    localparam logic [7:0]  MASK_A1         = 8'he0;
    localparam logic [7:0]  MASK_A0         = 8'h08;
    localparam logic [7:0]  MASK_W2         = 8'hc0;

    typedef struct packed {
        logic [7:0] latched_alarm_group3;
        logic [7:0] latched_alarm_group2;
        logic [7:0] latched_alarm_group1;
        logic [7:0] alarm0;
        logic [7:0] latched_warning_group3;
    } live_flags_t;

    typedef struct packed {
        logic done;
        logic above_high;
        logic below_low;
    } mon_meas_t;

    typedef struct packed {
        logic below_trip;
        logic done;
        logic above_low;
    } supply_meas_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [7:0] a3;
        logic [7:0] a2;
        logic [7:0] a1;
        logic [7:0] a0;
        logic [7:0] w3;
        logic [7:0] w2;
    } latched_t;

    typedef struct packed {
        logic [7:0]  third_monitor_input_warn;
        logic [31:0] entry;
        logic [7:0]  page;
        latched_t    lat;
        logic        lvl1;
        logic        lvl2;
        logic        supply_low;
        logic        armed;
        logic [7:0]  rdata;
        logic        rd_valid;
    } state_t;

endpackage

// >>> host_model.sv
// Host model that issues single register requests on the flag bank port
`timescale 1ns/1ps
module host_model
    import pgm_regs_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rd_valid,
    output reg_req_t        req
);
    initial req = '{rd: 1'b0, wr: 1'b0, addr: 8'h00, wdata: 8'h00};

    // Released address and data are inverted so nothing can lean on stale values
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge ref_clk);
        #1;
        req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge ref_clk);
        #1;
        req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        #1;
        req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
        v = reg_rd_valid;
        d = reg_rdata;
    endtask
endmodule // host_model

// >>> password_gated_monitor_flag_regs_test.sv
// Self-checking bench for the password gated flag register bank
`timescale 1ns/1ps
`define CHK(g, e) check_val(64'(g), 64'(e))
module password_gated_monitor_flag_regs_test
    import pgm_regs_pkg::*;
();

    logic         ref_clk;
    logic         rst_n;
    logic         clk_en;
    reg_req_t     req;
    live_flags_t  live;
    mon_meas_t    third_monitor_input;
    supply_meas_t supply;
    logic [31:0]  lower_ref_pass;
    logic [31:0]  upper_ref_pass;
    logic [7:0]   reg_rdata;
    logic         reg_rd_valid;
    logic [7:0]   page_select;
    logic [7:0]   monitor3_warning_live;
    logic         supply_low_flag;
    logic         lower_access_level;
    logic         upper_access_level;
    int           bad_count = 0;
    int           num_checks = 0;
    logic [7:0]   lat_exp [6] = '{8'hef, MASK_A2, MASK_A1, MASK_A0, 8'hef, MASK_W2};

    password_gated_monitor_flag_regs password_gated_monitor_flag_regs_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .req(req), .live(live),
        .third_monitor_input(third_monitor_input), .supply(supply), .lower_ref_pass(lower_ref_pass),
        .upper_ref_pass(upper_ref_pass), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .page_select(page_select), .monitor3_warning_live(monitor3_warning_live),
        .supply_low_flag(supply_low_flag), .lower_access_level(lower_access_level),
        .upper_access_level(upper_access_level));

    host_model host_model_i (
        .ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .req(req));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_model_i.write_reg(a, d);
    endtask

    // Valid and data are compared together, a missing strobe fails as well
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       v;
        host_model_i.read_reg(a, d, v);
        `CHK({v, d}, {1'b1, e});
    endtask

    // Most significant byte goes to the lowest address; grant shows one edge after the last byte
    task automatic pass_write(input logic [31:0] pw);
        for (int i = 0; i < 4; i++)
            wr(PASS_FIRST + 8'(i), pw[31 - 8 * i -: 8]);
        @(posedge ref_clk);
        #1;
    endtask

    task automatic meas(input logic hi, input logic lo);
        @(posedge ref_clk);
        #1;
        third_monitor_input = '{done: 1'b1, above_high: hi, below_low: lo};
        @(posedge ref_clk);
        #1;
        third_monitor_input = '{done: 1'b0, above_high: ~hi, below_low: ~lo};
    endtask

    task automatic supply_pulse(input supply_meas_t s);
        @(posedge ref_clk);
        #1;
        supply = s;
        @(posedge ref_clk);
        #1;
        supply = '{below_trip: 1'b0, done: 1'b0, above_low: ~s.above_low};
    endtask

    initial begin
        #25000;
        bad_count++;
        conclude();
    end

    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        live = '0;
        third_monitor_input = '0;
        supply = '0;
        lower_ref_pass = 32'hffffffff;
        upper_ref_pass = 32'h5a5a0f0f;
        repeat (16) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK(lower_access_level, 1'b1);
        `CHK(upper_access_level, 1'b0);
        `CHK(supply_low_flag, 1'b1);
        lower_ref_pass = 32'h11223344;
        rd(THIRD_MONITOR_INPUT_WARN_ADDR, THIRD_MONITOR_INPUT_WARN_RST);
        rd(PAGE_SEL_ADDR, PAGE_RST);
        `CHK(page_select, PAGE_RST);
        for (int a = RSVD_LO_FIRST; a <= PASS_LAST; a++)
            rd(8'(a), READ_ZERO);
        for (int p = 1; p <= 5; p++) begin
            wr(PAGE_SEL_ADDR, 8'(p));
            rd(PAGE_SEL_ADDR, 8'(p));
        end
        rd(LAT_A3_ADDR, READ_ZERO);
        wr(PAGE_SEL_ADDR, PAGE_LATCHED);
        `CHK(page_select, PAGE_LATCHED);
        wr(NV_FIRST, 8'h5a);
        rd(NV_FIRST, READ_ZERO);
        pass_write(32'h11223344);
        `CHK({lower_access_level, upper_access_level}, 2'b10);
        wr(NV_FIRST, 8'h5a);
        rd(NV_FIRST, 8'h5a);
        pass_write(upper_ref_pass);
        `CHK({lower_access_level, upper_access_level}, 2'b11);
        wr(NV_LAST, 8'h3c);
        rd(NV_LAST, 8'h3c);
        meas(1'b1, 1'b0);
        `CHK(monitor3_warning_live, 8'h90);
        meas(1'b0, 1'b1);
        rd(THIRD_MONITOR_INPUT_WARN_ADDR, 8'h50);
        meas(1'b0, 1'b0);
        rd(THIRD_MONITOR_INPUT_WARN_ADDR, THIRD_MONITOR_INPUT_WARN_RST);
        @(posedge ref_clk);
        #1;
        live = '1;
        @(posedge ref_clk);
        #1;
        live = '0;
        for (int i = 0; i < 6; i++)
            rd(LAT_A3_ADDR + 8'(i), lat_exp[i]);
        wr(PASS_LAST, 8'h00);
        @(posedge ref_clk);
        #1;
        `CHK({lower_access_level, upper_access_level}, 2'b00);
        wr(LAT_A3_ADDR, 8'hff);
        rd(LAT_A3_ADDR, lat_exp[0]);
        pass_write(32'h11223344);
        for (int i = 0; i < 6; i++) begin
            wr(LAT_A3_ADDR + 8'(i), 8'h00);
            rd(LAT_A3_ADDR + 8'(i), LATCH_RST);
        end
        supply_pulse('{below_trip: 1'b0, done: 1'b1, above_low: 1'b1});
        `CHK(supply_low_flag, 1'b0);
        supply_pulse('{below_trip: 1'b1, done: 1'b0, above_low: 1'b0});
        `CHK(supply_low_flag, 1'b1);
        rd(LAT_W3_ADDR, 8'h10);
        supply_pulse('{below_trip: 1'b0, done: 1'b1, above_low: 1'b1});
        `CHK(supply_low_flag, 1'b0);
        rd(LAT_W3_ADDR, 8'h10);
        // Live flag still high while the clear lands: the set has to win
        live.alarm0 = MASK_A0;
        wr(LAT_A0_ADDR, 8'h00);
        live.latched_alarm_group3[SUPPLY_LO_BIT] = 1'b1;
        @(posedge ref_clk);
        #1;
        live = '0;
        rd(LAT_A0_ADDR, MASK_A0);
        rd(LAT_A3_ADDR, 8'h10);
        // With the enable low, neither a write nor a conversion may move anything
        clk_en = 1'b0;
        wr(PAGE_SEL_ADDR, 8'h03);
        meas(1'b1, 1'b1);
        clk_en = 1'b1;
        `CHK(page_select, PAGE_LATCHED);
        `CHK(monitor3_warning_live, THIRD_MONITOR_INPUT_WARN_RST);
        conclude();
    end
endmodule // password_gated_monitor_flag_regs_test
